// File: rtl/spio_consts.vh
// Constants for the shared parallel I/O port: register offsets, reset values, width and pin masks.
// Assumes inclusion by bare name from the port module.
`ifndef SPIO_CONSTS_VH
`define SPIO_CONSTS_VH

`define SPIO_ADDR_W          4
`define SPIO_OFF_DIRECTION   4'h0
`define SPIO_OFF_LEVEL       4'h1
`define SPIO_OFF_LATCH       4'h2
`define SPIO_OFF_ANALOG      4'h3
`define SPIO_OFF_PERIPH_EN   4'h4
`define SPIO_WIDTH           16
`define SPIO_IMPL_MASK       16'hffff
`define SPIO_RST_DIRECTION   16'hffff
`define SPIO_RST_LATCH       16'h0000
`define SPIO_RST_ANALOG      16'h0000
`define SPIO_RST_PERIPH_EN   16'h0000
`define SPIO_INPUT_ONLY_MASK 16'h0000

`endif

// File: rtl/spio_port.v
// Shared parallel I/O port: direction, output latch and pin-level registers per pin,
// with peripheral/port multiplexing of pad output data and enable.
// Assumes a single 200 MHz clock, pins and peripheral signals synchronous or
// asynchronous levels (pins are synchronised here), and a plain register port.
//
// Summary of operation
// R01: Active peripheral drive takes the pad; port driver off, pin still readable.
// R02: Enabled but idle peripheral lets the port drive the pin from its latch.
// R03: Direction bit 1 makes the pin an input; 0 drives the latch.
// R04: Reset sets every direction bit so all pins start as inputs.
// R05: Latch register read returns stored latch contents, not pin levels.
// R06: Latch register write updates latch feeding the pad drivers.
// R07: Pin-level read returns sampled pin state whatever the direction.
// R08: Pin-level write goes into the output latch, nothing else.
// R09: Unimplemented bits are disabled and read zero in every register.
// R10: Pins shared only with input-only functions act as dedicated port pins.
// R11: Per pin, two muxes pick peripheral or port for pad data and enable.
// R12: Each pin has exactly direction, latch and pin-level registers; the code also gives each pin analog-select and peripheral-enable bits.
// R13: Software waits one instruction cycle between a port write and its read.
// R14: Pins selected analog read low in the pin-level register.
// R15: Pin inputs pass a two-stage synchroniser before pin-level reads.
`timescale 1ns/1ps
`include "spio_consts.vh"

module spio_port
#(
   parameter                   WIDTH           = `SPIO_WIDTH,
   parameter [WIDTH-1:0]       IMPL_MASK       = `SPIO_IMPL_MASK,
   parameter [WIDTH-1:0]       INPUT_ONLY_MASK = `SPIO_INPUT_ONLY_MASK
)
(
   input  wire                    clock_in,
   input  wire                    rstn_in,
   input  wire [`SPIO_ADDR_W-1:0] addr_in,
   input  wire [WIDTH-1:0]        wdata_in,
   input  wire                    wr_in,
   input  wire                    rd_in,
   output reg  [WIDTH-1:0]        rdata_out,
   input  wire [WIDTH-1:0]        pad_in,
   output reg  [WIDTH-1:0]        pad_out,
   output reg  [WIDTH-1:0]        pad_oen_out,
   input  wire [WIDTH-1:0]        periph_drive_in,
   input  wire [WIDTH-1:0]        periph_data_in,
   output reg  [WIDTH-1:0]        pin_level_out
);

   // Pins that a peripheral may claim; input-only sharers never compete
   localparam [WIDTH-1:0] SHARED_MASK = IMPL_MASK & ~INPUT_ONLY_MASK;

   reg  [WIDTH-1:0] pin_direction_reg;
   reg  [WIDTH-1:0] output_latch_reg;
   reg  [WIDTH-1:0] analog_pin_select_reg;
   reg  [WIDTH-1:0] periph_enable_reg;
   reg  [WIDTH-1:0] sync_first;
   reg  [WIDTH-1:0] sync_second;
   reg  [WIDTH-1:0] pin_level_reg;
   reg  [WIDTH-1:0] next_rdata;
   reg  [WIDTH-1:0] next_pad_out;
   reg  [WIDTH-1:0] next_pad_oen;
   wire [WIDTH-1:0] periph_owns;
   wire [WIDTH-1:0] pin_level_value;

   // Peripheral owns a pad only while enabled and actively driving
   assign periph_owns = periph_enable_reg & periph_drive_in & SHARED_MASK; // [R01] [R02] [R10]

   // Analog pins read low; unimplemented bits read zero
   assign pin_level_value = sync_second & ~analog_pin_select_reg & IMPL_MASK; // [R14] [R09]

   // Register writes; level and latch offsets both land in the latch
   always @(posedge clock_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         pin_direction_reg     <= `SPIO_RST_DIRECTION; // [R04]
         output_latch_reg      <= `SPIO_RST_LATCH;
         analog_pin_select_reg <= `SPIO_RST_ANALOG;
         periph_enable_reg     <= `SPIO_RST_PERIPH_EN;
      end
      else if (wr_in)
      begin
         case (addr_in)
            `SPIO_OFF_DIRECTION: pin_direction_reg <= wdata_in & IMPL_MASK; // [R09] [R12]
            `SPIO_OFF_LATCH:     output_latch_reg  <= wdata_in & IMPL_MASK; // [R06]
            `SPIO_OFF_LEVEL:     output_latch_reg  <= wdata_in & IMPL_MASK; // [R08]
            `SPIO_OFF_ANALOG:    analog_pin_select_reg <= wdata_in & IMPL_MASK;
            `SPIO_OFF_PERIPH_EN: periph_enable_reg <= wdata_in & SHARED_MASK;
            default:             output_latch_reg  <= output_latch_reg;
         endcase
      end
   end

   // Two-stage synchroniser; first stage feeds only the second
   always @(posedge clock_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         sync_first    <= {WIDTH{1'b0}};
         sync_second   <= {WIDTH{1'b0}};
         pin_level_reg <= {WIDTH{1'b0}};
      end
      else
      begin
         sync_first    <= pad_in;          // [R15]
         sync_second   <= sync_first;      // [R15]
         pin_level_reg <= pin_level_value; // [R07]
      end
   end

   // Read mux; unmapped offsets read zero
   always @*
   begin
      case (addr_in)
         `SPIO_OFF_DIRECTION: next_rdata = pin_direction_reg & IMPL_MASK; // [R09]
         `SPIO_OFF_LATCH:     next_rdata = output_latch_reg & IMPL_MASK;  // [R05]
         `SPIO_OFF_LEVEL:     next_rdata = pin_level_value;               // [R07]
         `SPIO_OFF_ANALOG:    next_rdata = analog_pin_select_reg;
         `SPIO_OFF_PERIPH_EN: next_rdata = periph_enable_reg;
         default:             next_rdata = {WIDTH{1'b0}};
      endcase
   end

   // Pad data and enable muxes; enable is active low, unimplemented pins float
   always @*
   begin
      next_pad_out = (periph_owns & periph_data_in)
                   | (~periph_owns & output_latch_reg); // [R11]
      next_pad_oen = (periph_owns & {WIDTH{1'b0}})
                   | (~periph_owns & pin_direction_reg); // [R11] [R03] [R01]
      next_pad_oen = next_pad_oen | ~IMPL_MASK; // [R09]
      next_pad_out = next_pad_out & IMPL_MASK;
   end

   // Outputs are registered, so pad changes trail the cause by one cycle
   always @(posedge clock_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         rdata_out     <= {WIDTH{1'b0}};
         pad_out       <= {WIDTH{1'b0}};
         pad_oen_out   <= {WIDTH{1'b1}};
         pin_level_out <= {WIDTH{1'b0}};
      end
      else
      begin
         rdata_out     <= rd_in ? next_rdata : {WIDTH{1'b0}};
         pad_out       <= next_pad_out;
         pad_oen_out   <= next_pad_oen;
         pin_level_out <= pin_level_reg;
      end
   end

endmodule

// File: dv/spio_port_monitor.sv
// Checker for spio_port: register bus, pad muxes and pin levels.
// Assumes default offsets and all 16 pins implemented.
`timescale 1ns/1ps
module spio_port_monitor (
   input wire        clock_in, rstn_in, wr_in, rd_in,
   input wire [3:0]  addr_in,
   input wire [15:0] wdata_in, rdata_out, pad_in, pad_out, pad_oen_out,
   input wire [15:0] periph_drive_in, pin_level_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rstn_in);
   sequence s_lat_wr; wr_in && (addr_in == 4'h1 || addr_in == 4'h2); endsequence
   sequence s_quiet; !wr_in && periph_drive_in == 16'h0000; endsequence
   sequence s_steady; $stable(pad_in) [*4]; endsequence
   property p_oen_rst; $rose(rstn_in) |-> pad_oen_out == 16'hffff; endproperty
   property p_rd_idle; !$past(rd_in) |-> rdata_out == 16'h0000; endproperty
   property p_lat_pad; s_lat_wr ##1 s_quiet
      |=> ((pad_out ^ $past(wdata_in, 2)) & ~pad_oen_out) == 16'h0000; endproperty
   property p_lat_rd; s_lat_wr ##1 (rd_in && addr_in == 4'h2)
      |=> rdata_out == $past(wdata_in, 2); endproperty
   property p_dir_oen; wr_in && addr_in == 4'h0 ##1 s_quiet
      |=> pad_oen_out == $past(wdata_in, 2); endproperty
   property p_unmap; rd_in && addr_in > 4'h4 |=> rdata_out == 16'h0000; endproperty
   property p_lvl_rd; s_steady ##0 (rd_in && addr_in == 4'h1)
      |=> (rdata_out & ~$past(pad_in)) == 16'h0000; endproperty
   property p_pin_lvl; s_steady |-> (pin_level_out & ~pad_in) == 16'h0000; endproperty
   a_oen_rst: assert property (p_oen_rst) else $error("pads not inputs after reset");
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
   a_lat_pad: assert property (p_lat_pad) else $error("pad data not latch");
   a_lat_rd: assert property (p_lat_rd) else $error("latch readback wrong");
   a_dir_oen: assert property (p_dir_oen) else $error("pad enable not direction");
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   a_lvl_rd: assert property (p_lvl_rd) else $error("level read not from pins");
   a_pin_lvl: assert property (p_pin_lvl) else $error("pin level not from pins");
endmodule

// File: dv/spio_pins_model.sv
// Pin model: resolves each pad from the port driver or an external source.
// Assumes active-low pad enable; a released pad follows the external level.
`timescale 1ns/1ps
module spio_pins_model (
   input  wire [15:0] drive_in,
   input  wire [15:0] oen_in,
   input  wire [15:0] ext_in,
   output wire [15:0] level_out
);
   // External source yields where the port drives, so no contention is modelled
   assign level_out = (drive_in & ~oen_in) | (ext_in & oen_in);
endmodule

// File: dv/spio_port_bench.sv
// Self-checking bench for spio_port: register tasks, pin and peripheral cases.
// Assumes default offsets and all 16 pins implemented.
`timescale 1ns/1ps
module spio_port_bench;
   logic        clock_in = 0, rstn_in = 0, wr_in = 0, rd_in = 0;
   logic [3:0]  addr_in = 0;
   logic [15:0] wdata_in = 0, periph_drive_in = 0, periph_data_in = 0, ext = 16'h5a5a;
   wire  [15:0] rdata_out, pad_in, pad_out, pad_oen_out, pin_level_out;
   int          n_fail = 0, num_checks = 0;
   spio_port i_spio_port(.clock_in, .rstn_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
      .pad_in, .pad_out, .pad_oen_out, .periph_drive_in, .periph_data_in, .pin_level_out);
   spio_pins_model i_spio_pins_model(.drive_in(pad_out), .oen_in(pad_oen_out), .ext_in(ext),
      .level_out(pad_in));
   initial forever #2.5 clock_in = ~clock_in;
   task final_report;
      $display("checks %0d failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task chk(input string n, input logic [15:0] g, e);
      num_checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   task bus(input logic w, r, input logic [3:0] a, input logic [15:0] d);
      @(posedge clock_in);
      {wr_in, rd_in, addr_in, wdata_in} <= {w, r, a, d};
   endtask
   task wr(input logic [3:0] a, input logic [15:0] d);
      bus(1'h1, 1'h0, a, d);
   endtask
   // Every write is followed by a read, which returns the bus to idle
   task rdchk(input string n, input logic [3:0] a, input logic [15:0] e);
      bus(1'h0, 1'h1, a, 16'h0000);
      bus(1'h0, 1'h0, a, 16'h0000);
      #1 chk(n, rdata_out, e);
   endtask
   initial
   begin
      repeat (20) @(posedge clock_in);
      rstn_in <= 1'h1;
      rdchk("direction", 4'h0, 16'hffff);
      chk("pad enable", pad_oen_out, 16'hffff);
      wr(4'h2, 16'ha5a5);
      rdchk("latch", 4'h2, 16'ha5a5);
      wr(4'h0, 16'hff00);
      rdchk("direction", 4'h0, 16'hff00);
      repeat (4) @(posedge clock_in);
      #1 chk("pad enable", pad_oen_out, 16'hff00);
      chk("pad data", pad_out, 16'ha5a5);
      chk("pin level out", pin_level_out, 16'h5aa5);
      rdchk("pin level", 4'h1, 16'h5aa5);
      wr(4'h1, 16'h1234);
      rdchk("latch", 4'h2, 16'h1234);
      wr(4'h4, 16'h000f);
      rdchk("periph enable", 4'h4, 16'h000f);
      wr(4'h0, 16'hff03);
      rdchk("direction", 4'h0, 16'hff03);
      @(posedge clock_in);
      {periph_drive_in, periph_data_in} <= {16'h0003, 16'h0002};
      repeat (4) @(posedge clock_in);
      #1 chk("pad data", pad_out, 16'h1236);
      chk("pad enable", pad_oen_out, 16'hff00);
      rdchk("pin level", 4'h1, 16'h5a36);
      wr(4'h3, 16'h00f0);
      rdchk("analog select", 4'h3, 16'h00f0);
      rdchk("pin level", 4'h1, 16'h5a06);
      wr(4'hf, 16'hffff);
      rdchk("unmapped", 4'hf, 16'h0000);
      final_report;
   end
   initial
   begin
      #20000;
      n_fail++;
      final_report;
   end
endmodule
bind spio_port spio_port_monitor i_spio_port_monitor(.clock_in, .rstn_in, .wr_in, .rd_in,
   .addr_in, .wdata_in, .rdata_out, .pad_in, .pad_out, .pad_oen_out, .periph_drive_in,
   .pin_level_out);
